//--- inc/ddr3_guard_params.svh
// Timing constants for the DDR3 command timing guard on the controller side.
// Assumes the link clock is the memory clock and the system clock runs at 10 MHz.
// Contract
// - Fixed chop4 write: WL+2+WR clocks before power-down
// - Fixed chop4 autoprecharge write: WL+2+WR+1 before power-down
// - Refresh to power-down at least 1 clock
// - Mode register set to power-down: update delay
// - ODT high at least 4 clocks, short
// - ODT high at least 6 clocks, eight-beat write
// - Leveling: 40 clocks before first strobe edge
// - Leveling: 25 clocks before strobe drivers on
// - Refresh to activate or refresh: 90 ns
// - Average refresh interval 7.8 or 3.9 us
// - DLL-locked commands wait longer exit delay
// - Write recovery ns to clocks rounds up
// - Autoprecharge recovery uses programmed clock count
// - Clock may be slow if refresh met
// - Eight-beat write: WL+4+WR before power-down
// - CKE low allowed while operations still run
`ifndef DDR3_GUARD_PARAMS_SVH
`define DDR3_GUARD_PARAMS_SVH
`define LINK_CK_PS          32'd64000
`define SYS_CK_NS           32'd100
`define RFC_NS              32'd90
`define RFC_CK              (((`RFC_NS * 32'd1000) + `LINK_CK_PS - 32'd1) / `LINK_CK_PS)
`define REFI_NORM_NS        32'd7800
`define REFI_HOT_NS         32'd3900
`define REFI_NORM_CYC       (`REFI_NORM_NS / `SYS_CK_NS)
`define REFI_HOT_CYC        (`REFI_HOT_NS / `SYS_CK_NS)
`define REF_PDEN_CK         8'h01
`define MOD_CK              8'h0C
`define ODTH_SHORT_CK       8'h04
`define ODTH_LONG_CK        8'h06
`define WL_STROBE_CK        8'h28
`define WL_DQSEN_CK         8'h19
`define CHOP_FIXED_ADD      8'h02
`define CHOP_OTF_ADD        8'h04
`define ODT_LAT_SUB         8'h02
`define XPDLL_CK            8'h0A
`define XP_CK               8'h03
`endif

//--- inc/ddr3_guard_pkg.sv
// Types shared by the DDR3 command timing guard.
// Assumes the constants header is included where numbers are needed.
package ddr3_guard_pkg;
  typedef enum logic [2:0] {
    cmd_none_type_v, cmd_wr, cmd_wra, cmd_ref, cmd_mrs, cmd_act, cmd_rd, cmd_lvl
  } cmd_kind_type;

  typedef struct packed {
    cmd_kind_type kind;
    logic         eight_beat_burst;
    logic         needs_dll;
  } cmd_req_type;

  typedef struct packed {
    logic [7:0] write_latency_clocks;
    logic [7:0] cas_write_delay;
    logic [7:0] added_delay;
    logic [7:0] wr_recovery_clocks;
    logic       fixed_chop4_mode;
    logic       hot_range;
  } timing_cfg_type;
endpackage

//--- hdl/ddr3_cmd_timing_guard.sv
// Controller-side guard that spaces DDR3 commands, CKE, ODT and strobes.
// Assumes requests come from the system clock domain and the pins run on the link clock.
`timescale 1ns/1ps
`include "ddr3_guard_params.svh"
module ddr3_cmd_timing_guard
  import ddr3_guard_pkg::*;
(
  // System side
  input  wire logic           clk_sys_in,
  input  wire logic           rst_b_in,
  input  wire cmd_req_type    req_in,
  input  wire logic           req_valid_in,
  output logic                req_ready_out,
  input  wire timing_cfg_type cfg_in,
  input  wire logic           pd_req_in,
  output logic                refresh_due_out,
  // Link side
  input  wire logic           clk_link_in,
  output logic [2:0]          cmd_kind_out,
  output logic                cmd_strobe_out,
  output logic                cke_out,
  output logic                odt_out,
  output logic                dqs_oe_out,
  output logic                dqs_rise_ok_out,
  output logic [7:0]          term_on_lat_out,
  output logic [7:0]          write_start_lat_out
);
  // Request hand-off: a toggle handshake so a single command crosses once.
  logic         req_tgl_reg;
  cmd_req_type  req_hold_reg;
  logic [1:0]   ack_sync_reg;
  logic         busy;
  logic         pd_s1_reg;
  logic         pd_s2_reg;
  logic         l_req_s1_reg;
  logic         l_req_s2_reg;
  logic         l_req_s3_reg;
  logic         l_ack_reg;
  logic         l_rst_s1_reg;
  logic         l_rst_b;

  // Reset release into the link domain.
  always_ff @(posedge clk_link_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      l_rst_s1_reg <= 1'b0;
      l_rst_b      <= 1'b0;
    end else begin
      l_rst_s1_reg <= 1'b1;
      l_rst_b      <= l_rst_s1_reg;
    end
  end

  assign busy          = req_tgl_reg != ack_sync_reg[1];
  assign req_ready_out = !busy;

  // The acknowledge passes two flops before the request side reads it.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_sync_reg <= 2'b00;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], l_ack_reg};
    end
  end

  // The held request stays still while busy, so the link side reads it safely.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_tgl_reg  <= 1'b0;
      req_hold_reg <= '0;
    end else if (req_valid_in && !busy) begin
      req_hold_reg <= req_in;
      req_tgl_reg  <= !req_tgl_reg;
    end
  end

  // Refresh interval timer in the system domain; it does not depend on link speed.
  logic [15:0] refi_cnt_reg;
  logic [15:0] refi_load;
  assign refi_load = cfg_in.hot_range ? 16'(`REFI_HOT_CYC) : 16'(`REFI_NORM_CYC);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Reset starts a full interval, so no refresh is flagged at once.
      refi_cnt_reg    <= 16'(`REFI_NORM_CYC);
      refresh_due_out <= 1'b0;
    end else begin
      // A refresh request restarts the interval; otherwise count down to zero, then hold there and flag refresh due.
      if (req_valid_in && !busy && req_in.kind == cmd_ref) begin
        refi_cnt_reg    <= refi_load;
        refresh_due_out <= 1'b0;
      end else if (refi_cnt_reg == 16'h0000) begin
        refresh_due_out <= 1'b1;
      end else begin
        refi_cnt_reg <= refi_cnt_reg - 16'h0001;
      end
    end
  end

  // Link domain: the configuration is treated as quasi-static.
  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  function automatic logic kind_is(input cmd_kind_type have,
                                   input cmd_kind_type want);
    kind_is = have == want;
  endfunction

  // Each spacing has its own down-counter, except the spacings to power-down, which share one.
  logic [7:0] pden_cnt_reg;
  logic [7:0] pden_cnt_next;
  logic [7:0] rfc_cnt_reg;
  logic [7:0] rfc_cnt_next;
  logic [7:0] odt_cnt_reg;
  logic [7:0] odt_cnt_next;
  logic [7:0] dqsen_cnt_reg;
  logic [7:0] dqsen_cnt_next;
  logic [7:0] strobe_cnt_reg;
  logic [7:0] strobe_cnt_next;
  logic [7:0] dll_cnt_reg;
  logic [7:0] dll_cnt_next;

  logic [7:0] wl;
  logic [7:0] wr_gap;
  logic [7:0] wra_gap;
  logic [7:0] write_gap;
  logic [7:0] burst_add;
  logic [7:0] odt_hold;

  logic       new_req;
  logic       issue;
  logic       blocked;
  logic       ref_blocked;
  logic       dll_blocked;
  logic       is_ref_or_act;

  logic       is_write;
  logic       is_wra;
  logic       is_ref;
  logic       is_mrs;
  logic       is_lvl;

  logic       odt_clear;
  logic       pd_enter;
  logic       pd_leave;
  logic       lvl_active_reg;
  logic       was_pd_reg;

  assign wl        = cfg_in.write_latency_clocks;
  // Recovery is already a rounded-up clock count from mode_reg_zero.
  assign burst_add = cfg_in.fixed_chop4_mode ? `CHOP_FIXED_ADD : `CHOP_OTF_ADD;
  // Write spacing to power-down.
  assign wr_gap    = wl + burst_add + cfg_in.wr_recovery_clocks;
  // Autoprecharge write spacing adds one more clock.
  assign wra_gap   = wr_gap + 8'h01;

  assign new_req  = l_req_s3_reg != l_req_s2_reg;
  assign is_write = issue && (kind_is(req_hold_reg.kind, cmd_wr)
                              || kind_is(req_hold_reg.kind, cmd_wra));
  assign is_wra   = issue && kind_is(req_hold_reg.kind, cmd_wra);
  assign is_ref   = issue && kind_is(req_hold_reg.kind, cmd_ref);
  assign is_mrs   = issue && kind_is(req_hold_reg.kind, cmd_mrs);
  assign is_lvl   = issue && kind_is(req_hold_reg.kind, cmd_lvl);

  // Activate and refresh wait out refresh recovery.
  assign is_ref_or_act = kind_is(req_hold_reg.kind, cmd_ref)
                         || kind_is(req_hold_reg.kind, cmd_act);
  assign ref_blocked   = is_ref_or_act && rfc_cnt_reg != 8'h00;
  // DLL users wait the exit delay after power-down.
  assign dll_blocked   = req_hold_reg.needs_dll && dll_cnt_reg != 8'h00;
  assign blocked       = ref_blocked || dll_blocked;
  // A blocked command keeps ready low, since the ack only follows an issue.
  assign issue         = new_req && !blocked;

  assign write_gap = is_wra ? wra_gap : wr_gap;
  // Eight-beat writes hold ODT longer than chop4 ones.
  assign odt_hold  = (req_hold_reg.eight_beat_burst && !cfg_in.fixed_chop4_mode)
                     ? `ODTH_LONG_CK : `ODTH_SHORT_CK;
  assign odt_clear = odt_cnt_reg == 8'h00;

  // Power-down spacing keeps the longest pending requirement.
  assign pden_cnt_next   = is_write ? max8(pden_cnt_reg, write_gap)
                         : is_ref   ? max8(pden_cnt_reg, `REF_PDEN_CK)
                         : is_mrs   ? max8(pden_cnt_reg, `MOD_CK)
                         : is_lvl   ? max8(pden_cnt_reg, `MOD_CK)
                         : dec8(pden_cnt_reg);
  assign rfc_cnt_next    = is_ref ? 8'(`RFC_CK) : dec8(rfc_cnt_reg);
  assign odt_cnt_next    = is_write ? odt_hold : dec8(odt_cnt_reg);
  assign dqsen_cnt_next  = is_lvl ? `WL_DQSEN_CK : dec8(dqsen_cnt_reg);
  assign strobe_cnt_next = is_lvl ? `WL_STROBE_CK : dec8(strobe_cnt_reg);
  assign dll_cnt_next    = (pd_leave && was_pd_reg) ? `XPDLL_CK
                         : dec8(dll_cnt_reg);

  // Latencies the device applies, shown for the data path.
  assign term_on_lat_out     = cfg_in.cas_write_delay + cfg_in.added_delay - `ODT_LAT_SUB;
  assign write_start_lat_out = wl + burst_add;
  assign dqs_rise_ok_out     = lvl_active_reg && strobe_cnt_reg == 8'h00;

  // CKE drops only with no request pending, the power-down spacing run out and ODT clear.
  assign pd_enter = pd_s2_reg && !new_req && pden_cnt_reg == 8'h00 && odt_clear;
  assign pd_leave = !pd_s2_reg;

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      pden_cnt_reg <= 8'h00;
    end else begin
      pden_cnt_reg <= pden_cnt_next;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      rfc_cnt_reg <= 8'h00;
    end else begin
      rfc_cnt_reg <= rfc_cnt_next;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      odt_cnt_reg <= 8'h00;
    end else begin
      odt_cnt_reg <= odt_cnt_next;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      dqsen_cnt_reg <= 8'h00;
    end else begin
      dqsen_cnt_reg <= dqsen_cnt_next;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      strobe_cnt_reg <= 8'h00;
    end else begin
      strobe_cnt_reg <= strobe_cnt_next;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      dll_cnt_reg <= 8'h00;
    end else begin
      dll_cnt_reg <= dll_cnt_next;
    end
  end

  // Only the second stage of each synchroniser feeds logic.
  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      l_req_s1_reg <= 1'b0;
      l_req_s2_reg <= 1'b0;
      pd_s1_reg    <= 1'b0;
      pd_s2_reg    <= 1'b0;
    end else begin
      l_req_s1_reg <= req_tgl_reg;
      l_req_s2_reg <= l_req_s1_reg;
      pd_s1_reg    <= pd_req_in;
      pd_s2_reg    <= pd_s1_reg;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      l_req_s3_reg <= 1'b0;
      l_ack_reg    <= 1'b0;
    end else if (issue) begin
      l_req_s3_reg <= l_req_s2_reg;
      l_ack_reg    <= l_req_s2_reg;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      cmd_strobe_out <= 1'b0;
      cmd_kind_out   <= 3'h0;
    end else begin
      cmd_strobe_out <= issue;
      if (issue) begin
        cmd_kind_out <= req_hold_reg.kind;
      end
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      odt_out <= 1'b0;
    end else if (is_write) begin
      odt_out <= 1'b1;
    end else if (odt_clear) begin
      odt_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      lvl_active_reg <= 1'b0;
      dqs_oe_out     <= 1'b0;
    end else begin
      lvl_active_reg <= lvl_active_reg || is_lvl;
      dqs_oe_out     <= lvl_active_reg && dqsen_cnt_reg == 8'h00;
    end
  end

  always_ff @(posedge clk_link_in or negedge l_rst_b) begin
    if (!l_rst_b) begin
      cke_out    <= 1'b0;
      was_pd_reg <= 1'b0;
    end else if (pd_enter) begin
      cke_out    <= 1'b0;
      was_pd_reg <= 1'b1;
    end else if (pd_leave) begin
      cke_out    <= 1'b1;
      was_pd_reg <= 1'b0;
    end
  end
endmodule

//--- verification/ddr3_guard_monitor.sv
// Checker on the guard's link pins.
// Assumes it is bound into the guard and sees only the guard's ports.
`timescale 1ns/1ps
module ddr3_guard_monitor
  import ddr3_guard_pkg::*;
(
  // Link side
  input wire logic           clk_link_in,
  input wire logic           rst_b_in,
  input wire timing_cfg_type cfg_in,
  input wire logic [2:0]     cmd_kind_out,
  input wire logic           cmd_strobe_out,
  input wire logic           cke_out,
  input wire logic           odt_out,
  input wire logic           dqs_oe_out,
  input wire logic           dqs_rise_ok_out
);
  default clocking @(posedge clk_link_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0] gap_reg;
  logic [7:0] age_reg;
  wire        wra_w = cmd_strobe_out && cmd_kind_out == cmd_wra;
  wire        wr_w = (cmd_strobe_out && cmd_kind_out == cmd_wr) || wra_w;
  wire [7:0]  gap_next = wr_w ? cfg_in.write_latency_clocks + cfg_in.wr_recovery_clocks
    + (cfg_in.fixed_chop4_mode ? 8'h02 : 8'h04) + {7'h00, wra_w}
    : gap_reg - {7'h00, gap_reg != 8'h00};
  // Age saturates so that strobes long after leveling never look early.
  wire [7:0]  age_next = (cmd_strobe_out && cmd_kind_out == cmd_lvl) ? 8'h00
    : age_reg + {7'h00, age_reg != 8'hFF};
  always_ff @(posedge clk_link_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap_reg <= 8'h00;
      age_reg <= 8'hFF;
    end else begin
      gap_reg <= gap_next;
      age_reg <= age_next;
    end
  end
  sequence s_ref_cmd; cmd_strobe_out && cmd_kind_out == cmd_ref; endsequence
  sequence s_mod_wait; cke_out [*8] ##1 cke_out [*3]; endsequence
  a_odt_short_hold: assert property ($rose(odt_out) |-> odt_out [*4])
    else $error("ODT pulse too short");
  a_ref_act_gap: assert property (s_ref_cmd |=> !(cmd_strobe_out
    && (cmd_kind_out == cmd_ref || cmd_kind_out == cmd_act))) else $error("Refresh gap");
  a_ref_cke_high: assert property (s_ref_cmd |-> cke_out)
    else $error("CKE low at refresh");
  a_wr_pd_gap: assert property ($fell(cke_out) |-> gap_reg <= 8'h01)
    else $error("Power-down too soon after write");
  a_mrs_pd_gap: assert property (cmd_strobe_out && cmd_kind_out == cmd_mrs && cke_out
    |=> s_mod_wait) else $error("Power-down too soon after mode set");
  a_lvl_oe_wait: assert property ($rose(dqs_oe_out) |-> age_reg >= 8'h18)
    else $error("Strobe driver enabled early");
  a_lvl_rise_wait: assert property ($rose(dqs_rise_ok_out) |-> age_reg >= 8'h27)
    else $error("Strobe edge allowed early");
  a_dll_exit_gap: assert property ($rose(cke_out)
    |=> !(cmd_strobe_out && cmd_kind_out == cmd_rd) [*8]) else $error("Read too soon after exit");
endmodule
bind ddr3_cmd_timing_guard ddr3_guard_monitor ddr3_guard_monitor_inst (
  .clk_link_in(clk_link_in), .rst_b_in(rst_b_in), .cfg_in(cfg_in),
  .cmd_kind_out(cmd_kind_out), .cmd_strobe_out(cmd_strobe_out), .cke_out(cke_out),
  .odt_out(odt_out), .dqs_oe_out(dqs_oe_out), .dqs_rise_ok_out(dqs_rise_ok_out));

//--- verification/ddr3_device_model.sv
// Behavioural memory device watching the guard's link pins.
// Assumes the same timing settings as the guard.
`timescale 1ns/1ps
module ddr3_device_model
  import ddr3_guard_pkg::*;
(
  // Link pins
  input  wire logic           clk_link_in,
  input  wire logic           rst_b_in,
  input  wire logic           odt_in,
  input  wire logic           cmd_strobe_in,
  input  wire logic [2:0]     cmd_kind_in,
  input  wire timing_cfg_type cfg_in,
  // Device state
  output logic                term_on_out,
  output logic                write_start_out
);
  logic [31:0] odt_hist_reg;
  logic [31:0] wr_hist_reg;
  wire  [7:0]  term_lat = cfg_in.cas_write_delay + cfg_in.added_delay - 8'h02;
  wire  [7:0]  start_lat = cfg_in.write_latency_clocks + (cfg_in.fixed_chop4_mode ? 8'h02 : 8'h04);
  wire         wr_cmd = cmd_strobe_in && (cmd_kind_in == cmd_wr || cmd_kind_in == cmd_wra);
  // Only edges are counted, so an arbitrarily slow clock is accepted.
  assign term_on_out = odt_hist_reg[term_lat[4:0] - 5'h01];
  assign write_start_out = wr_hist_reg[start_lat[4:0] - 5'h01];
  always_ff @(posedge clk_link_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      odt_hist_reg <= 32'h0;
      wr_hist_reg  <= 32'h0;
    end else begin
      odt_hist_reg <= {odt_hist_reg[30:0], odt_in};
      wr_hist_reg  <= {wr_hist_reg[30:0], wr_cmd};
    end
  end
endmodule

//--- verification/ddr3_cmd_timing_guard_tb_top.sv
// Self-checking bench for the DDR3 command timing guard.
// Assumes the guard's header and package are compiled first.
`timescale 1ns/1ps
module ddr3_cmd_timing_guard_tb_top
  import ddr3_guard_pkg::*;
();
  typedef struct { cmd_kind_type k; logic e8; logic dll; int odt_min; } row_type;
  logic clk_sys_in, rst_b_in, clk_link_in, req_valid_in, pd_req_in, req_ready_out;
  logic refresh_due_out, cmd_strobe_out, cke_out, odt_out, dqs_oe_out, dqs_rise_ok_out;
  logic [2:0] cmd_kind_out;
  logic term_on, write_start;
  logic [7:0] term_on_lat_out, write_start_lat_out;
  cmd_req_type req_in;
  timing_cfg_type cfg_in;
  int mismatches, compares, cyc, w, since_wr, t, s;
  row_type rows[8] = '{'{cmd_wr, 1, 0, 6}, '{cmd_wr, 0, 0, 4}, '{cmd_wra, 1, 0, 6},
    '{cmd_lvl, 0, 0, 0}, '{cmd_ref, 0, 0, 0}, '{cmd_mrs, 0, 0, 0}, '{cmd_act, 0, 0, 0},
    '{cmd_rd, 0, 1, 0}};
  ddr3_cmd_timing_guard ddr3_cmd_timing_guard_inst (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .req_in(req_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .cfg_in(cfg_in), .pd_req_in(pd_req_in),
    .refresh_due_out(refresh_due_out), .clk_link_in(clk_link_in), .cmd_kind_out(cmd_kind_out),
    .cmd_strobe_out(cmd_strobe_out), .cke_out(cke_out), .odt_out(odt_out),
    .dqs_oe_out(dqs_oe_out), .dqs_rise_ok_out(dqs_rise_ok_out),
    .term_on_lat_out(term_on_lat_out), .write_start_lat_out(write_start_lat_out));
  ddr3_device_model ddr3_device_model_inst (.clk_link_in(clk_link_in), .rst_b_in(rst_b_in),
    .odt_in(odt_out), .cmd_strobe_in(cmd_strobe_out), .cmd_kind_in(cmd_kind_out),
    .cfg_in(cfg_in), .term_on_out(term_on), .write_start_out(write_start));
  initial begin clk_sys_in = 0; forever #50 clk_sys_in = ~clk_sys_in; end
  initial begin clk_link_in = 0; #17; forever #32 clk_link_in = ~clk_link_in; end
  always @(posedge clk_link_in) since_wr <= (cmd_strobe_out && cmd_kind_out inside
    {cmd_wr, cmd_wra}) ? 0 : since_wr + 1;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin mismatches++; conclude(); end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task send(input cmd_kind_type k, input logic e8, input logic dll);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    while (req_ready_out !== 1'b1 && n < 50) begin @(negedge clk_sys_in); n++; end
    @(posedge clk_sys_in);
    req_in <= '{k, e8, dll};
    req_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    n = 0;
    while (cmd_strobe_out !== 1'b1 && n < 60) begin @(negedge clk_link_in); n++; end
  endtask
  initial begin
    rst_b_in = 0; req_valid_in = 0; pd_req_in = 0; req_in = '0; cyc = 0; since_wr = 0;
    mismatches = 0; compares = 0; cfg_in = '{8'h05, 8'h05, 8'h00, 8'h06, 1'b0, 1'b0};
    repeat (8) @(posedge clk_sys_in);
    chk({7'h00, cke_out}, 8'h00);
    rst_b_in <= 1'b1;
    chk(term_on_lat_out, 8'h03);
    chk(write_start_lat_out, 8'h09);
    repeat (70) @(negedge clk_sys_in);
    chk({7'h00, refresh_due_out}, 8'h00);
    repeat (12) @(negedge clk_sys_in);
    chk({7'h00, refresh_due_out}, 8'h01);
    foreach (rows[i]) begin
      send(rows[i].k, rows[i].e8, rows[i].dll);
      chk({5'h00, cmd_kind_out}, {5'h00, rows[i].k});
      w = 0;
      t = 0;
      s = 0;
      repeat (16) begin
        @(negedge clk_link_in);
        w += int'(odt_out === 1'b1);
        t += int'(term_on === 1'b1);
        s += int'(write_start === 1'b1);
      end
      chk({7'h00, w >= rows[i].odt_min}, 8'h01);
      chk({7'h00, t >= rows[i].odt_min}, 8'h01);
      chk(8'(s), (rows[i].k inside {cmd_wr, cmd_wra}) ? 8'h01 : 8'h00);
    end
    @(posedge clk_sys_in) cfg_in.fixed_chop4_mode <= 1'b1;
    @(negedge clk_sys_in) chk(write_start_lat_out, 8'h07);
    send(cmd_wra, 1'b0, 1'b0);
    @(posedge clk_sys_in) pd_req_in <= 1'b1;
    repeat (100) if (cke_out !== 1'b0) @(negedge clk_link_in);
    chk({7'h00, since_wr >= 14}, 8'h01);
    @(posedge clk_sys_in) pd_req_in <= 1'b0;
    send(cmd_rd, 1'b0, 1'b1);
    chk({5'h00, cmd_kind_out}, {5'h00, cmd_rd});
    conclude();
  end
endmodule
